//--- src/dcd_core.v
// Compute datapath: ALUs, dual MAC, 40-bit shifter, video ops, address unit
`timescale 1ns/1ps
`include "dcd_map.vh"
module dcd_core (
  input  wire                 mclk_in,
  input  wire                 resetn_in,
  input  wire                 op_valid_in,
  input  wire [`DCD_OP_W-1:0] op_code_in,
  input  wire [3:0]           op_dst_in,
  input  wire [3:0]           op_srca_in,
  input  wire [3:0]           op_srcb_in,
  input  wire [31:0]          op_imm_in,
  input  wire                 op_use_imm_in,
  input  wire                 op_half_in,
  input  wire                 op_signed_in,
  input  wire                 op_round_in,
  input  wire                 op_sat_in,
  output reg                  op_ready_out,
  output reg                  res_valid_out,
  output reg  [31:0]          res_data_out,
  output reg  [39:0]          acc0_out,
  output reg  [39:0]          acc1_out,
  input  wire                 ald_valid_in,
  input  wire [4:0]           ald_sel_in,
  input  wire [31:0]          ald_data_in,
  input  wire                 agen_valid_in,
  input  wire [1:0]           agen_set_in,
  input  wire [2:0]           agen_ptr_in,
  input  wire [31:0]          agen_off_in,
  output reg                  addr_valid_out,
  output reg  [31:0]          addr0_out,
  output reg  [31:0]          addr1_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] sat33;
    input [32:0] v;
    begin
      sat33 = (v[32] != v[31]) ? (v[32] ? `DCD_NEG32 : `DCD_POS32) : v[31:0];
    end
  endfunction

  function [15:0] sat17;
    input [16:0] v;
    begin
      sat17 = (v[16] != v[15]) ? (v[16] ? `DCD_NEG16 : `DCD_POS16) : v[15:0];
    end
  endfunction

  function [15:0] max16;
    input [15:0] x;
    input [15:0] y;
    begin
      max16 = ($signed(x) > $signed(y)) ? x : y;
    end
  endfunction

  function [31:0] circ;
    input [31:0] ix;
    input [31:0] md;
    input [31:0] ln;
    input [31:0] bs;
    reg   [31:0] nx;
    begin
      nx = ix + md;
      if (ln == 32'h0) circ = nx;
      else if (!md[31] && nx >= bs + ln) circ = nx - ln;
      else if (md[31] && nx < bs) circ = nx + ln;
      else circ = nx;
    end
  endfunction

  // ----------------------------------------
  // Issue and interlock
  // ----------------------------------------
  reg                 ex_valid_reg;
  reg [`DCD_OP_W-1:0] ex_op_reg;
  reg [3:0]           ex_dst_reg;
  reg                 ex_sa_hi_reg;
  reg                 ex_sb_hi_reg;
  reg [31:0]          ex_imm_reg;
  reg                 ex_use_imm_reg;
  reg                 ex_half_reg;
  reg                 ex_sgn_reg;
  reg                 ex_rnd_reg;
  reg                 ex_sat_reg;
  reg [39:0]          acc0_reg;
  reg [39:0]          acc1_reg;
  wire                accept = op_valid_in & op_ready_out;
  // Accumulator ops (MAC, SAA, SHFT) leave the register file alone and may issue back to back
  wire                op_writes = (op_code_in != `DCD_OP_MAC) && (op_code_in != `DCD_OP_SAA) &&
                                  (op_code_in != `DCD_OP_SHFT);
  wire [31:0]         rd_a;
  wire [31:0]         rd_b;

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_ready_out   <= 1'b1;
      ex_valid_reg   <= 1'b0;
      ex_op_reg      <= `DCD_OP_ADD;
      ex_dst_reg     <= 4'h0;
      ex_sa_hi_reg   <= 1'b0;
      ex_sb_hi_reg   <= 1'b0;
      ex_imm_reg     <= 32'h0;
      ex_use_imm_reg <= 1'b0;
      ex_half_reg    <= 1'b0;
      ex_sgn_reg     <= 1'b0;
      ex_rnd_reg     <= 1'b0;
      ex_sat_reg     <= 1'b0;
    end else begin
      // Writer holds off the next op until its write lands; read data are one cycle late
      op_ready_out   <= ~(accept & op_writes);
      ex_valid_reg   <= accept;
      if (accept) begin
        ex_op_reg      <= op_code_in;
        ex_dst_reg     <= op_dst_in;
        ex_sa_hi_reg   <= op_srca_in[0];
        ex_sb_hi_reg   <= op_srcb_in[0];
        ex_imm_reg     <= op_imm_in;
        ex_use_imm_reg <= op_use_imm_in;
        ex_half_reg    <= op_half_in;
        ex_sgn_reg     <= op_signed_in;
        ex_rnd_reg     <= op_round_in;
        ex_sat_reg     <= op_sat_in;
      end
    end
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  reg [31:0] a, b, res, res2, mul64_lo, x;
  reg [63:0] mul64;
  reg [15:0] a16, b16, r16;
  reg [16:0] h17, rem17;
  reg [32:0] s33;
  reg [33:0] p0, p1;
  reg [40:0] v41;
  reg [39:0] acc0_next, acc1_next, shv;
  reg [11:0] sad;
  reg [8:0]  t9;
  reg [5:0]  n;
  reg [4:0]  pos, len;
  reg        we0, we1, run;
  reg [1:0]  wm;
  integer    i;

  always @* begin
    a = rd_a;
    b = ex_use_imm_reg ? ex_imm_reg : rd_b;
    a16 = ex_sa_hi_reg ? a[31:16] : a[15:0];
    b16 = ex_use_imm_reg ? ex_imm_reg[15:0] : (ex_sb_hi_reg ? b[31:16] : b[15:0]);
    res = 32'h0;
    res2 = 32'h0;
    we0 = 1'b0;
    we1 = 1'b0;
    wm = 2'b11;
    acc0_next = acc0_reg;
    acc1_next = acc1_reg;
    mul64 = a * b;
    mul64_lo = mul64[31:0];
    p0 = $signed({ex_sgn_reg & a[15], a[15:0]}) * $signed({ex_sgn_reg & b[15], b[15:0]});
    p1 = $signed({ex_sgn_reg & a[31], a[31:16]}) * $signed({ex_sgn_reg & b[31], b[31:16]});
    v41 = {acc0_reg[39], acc0_reg} + (ex_rnd_reg ? {1'b0, `DCD_RND40} : 41'h0);
    pos = b[4:0];
    len = b[9:5];
    x = (32'h1 << len) - 32'h1;
    n = ex_imm_reg[5] ? (6'h0 - ex_imm_reg[5:0]) : ex_imm_reg[5:0];
    sad = 12'h0;
    s33 = 33'h0;
    h17 = 17'h0;
    rem17 = 17'h0;
    t9 = 9'h0;
    r16 = 16'h0;
    shv = acc0_reg;
    run = 1'b1;
    if (ex_valid_reg) begin
      we0 = 1'b1;
      case (ex_op_reg)
        `DCD_OP_ADD, `DCD_OP_SUB: begin
          s33 = (ex_op_reg == `DCD_OP_ADD) ? ({a[31], a} + {b[31], b}) : ({a[31], a} - {b[31], b});
          h17 = (ex_op_reg == `DCD_OP_ADD) ? ({a16[15], a16} + {b16[15], b16}) : ({a16[15], a16} - {b16[15], b16});
          r16 = ex_sat_reg ? sat17(h17) : h17[15:0];
          res = ex_half_reg ? {r16, r16} : (ex_sat_reg ? sat33(s33) : s33[31:0]);
        end
        `DCD_OP_AND: res = ex_half_reg ? {2{a16 & b16}} : a & b;
        `DCD_OP_OR:  res = ex_half_reg ? {2{a16 | b16}} : a | b;
        `DCD_OP_XOR: res = ex_half_reg ? {2{a16 ^ b16}} : a ^ b;
        `DCD_OP_ADD2: res = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
        `DCD_OP_SUB2: res = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
        `DCD_OP_QUAD: begin
          res  = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
          res2 = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
          we1  = 1'b1;
        end
        `DCD_OP_MUL: res = mul64_lo;
        `DCD_OP_POPC: for (i = 0; i < 32; i = i + 1) res = res + {31'h0, a[i]};
        `DCD_OP_SIGNB: for (i = 30; i >= 0; i = i - 1) begin
          run = run & (a[i] == a[31]);
          res = res + {31'h0, run};
        end
        `DCD_OP_EXTR: begin
          res = (a >> pos) & x;
          if (ex_sgn_reg && len != 5'h0 && res[len - 5'h1]) res = res | ~x;
        end
        `DCD_OP_DEPO: res = (a & ~(x << pos)) | (({16'h0, b[31:16]} & x) << pos);
        `DCD_OP_SHFT: begin
          we0 = 1'b0;
          case (ex_imm_reg[7:6])
            // Unsigned wrapper keeps the other branch from turning this into a logical shift
            `DCD_SH_ARITH: shv = ex_imm_reg[5] ? $unsigned($signed(acc0_reg) >>> n) : acc0_reg << n;
            `DCD_SH_LOGIC: shv = ex_imm_reg[5] ? acc0_reg >> n : acc0_reg << n;
            `DCD_SH_ROT: shv = ex_imm_reg[5] ?
              ((acc0_reg >> n) | (acc0_reg << (`DCD_ACC_W7 - {1'b0, n}))) :
              ((acc0_reg << n) | (acc0_reg >> (`DCD_ACC_W7 - {1'b0, n})));
            default: shv = acc0_reg;
          endcase
          acc0_next = shv;
        end
        `DCD_OP_MAC: begin
          we0 = 1'b0;
          acc0_next = acc0_reg + {{6{p0[33]}}, p0};
          acc1_next = acc1_reg + {{6{p1[33]}}, p1};
        end
        `DCD_OP_DIVS: begin
          rem17 = {a[31:16], a[15]};
          res = {a[31:16], a[14:0], 1'b0};
          if (rem17 >= {1'b0, b[15:0]}) begin
            rem17 = rem17 - {1'b0, b[15:0]};
            res = {rem17[15:0], a[14:0], 1'b1};
          end else
            res = {rem17[15:0], a[14:0], 1'b0};
        end
        `DCD_OP_RND: begin
          s33 = {a[31], a} + {1'b0, `DCD_RND32};
          r16 = sat17(s33[32:16]);
          res = {{16{r16[15]}}, r16};
        end
        `DCD_OP_ADD2C: res = {sat17({a[31], a[31:16]} + {b[31], b[31:16]}),
                              sat17({a[15], a[15:0]} + {b[15], b[15:0]})};
        `DCD_OP_ADD8C, `DCD_OP_AVG8, `DCD_OP_SAA: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (ex_op_reg == `DCD_OP_SAA) begin
              t9 = {1'b0, a[8*i +: 8]} - {1'b0, b[8*i +: 8]};
              sad = sad + {3'h0, (t9[8] ? (9'h0 - t9) : t9)};
            end else if (ex_op_reg == `DCD_OP_AVG8) begin
              t9 = {1'b0, a[8*i +: 8]} + {1'b0, b[8*i +: 8]} + 9'h1;
              res[8*i +: 8] = t9[8:1];
            end else begin
              t9 = {1'b0, a[8*i +: 8]} + {1'b0, b[8*i +: 8]};
              res[8*i +: 8] = t9[8] ? 8'hFF : t9[7:0];
            end
          end
          if (ex_op_reg == `DCD_OP_SAA) begin
            we0 = 1'b0;
            acc0_next = acc0_reg + {28'h0, sad};
          end
        end
        `DCD_OP_ALIGN: begin
          mul64 = {a, b} >> {ex_imm_reg[1:0], 3'h0};
          res = mul64[31:0];
        end
        `DCD_OP_PACK: res = {a[23:16], a[7:0], b[23:16], b[7:0]};
        `DCD_OP_MIN: res = ($signed(a) < $signed(b)) ? a : b;
        `DCD_OP_MAX: res = ($signed(a) > $signed(b)) ? a : b;
        `DCD_OP_VSRCH: res = {max16(a[31:16], b[31:16]), max16(a[15:0], b[15:0])};
        `DCD_OP_ACCRD: res = (&v41[40:31] | ~|v41[40:31]) ? v41[31:0] :
                             (ex_sat_reg ? (v41[40] ? `DCD_NEG32 : `DCD_POS32) : v41[31:0]);
        default: we0 = 1'b0;
      endcase
      if (ex_half_reg && ex_op_reg <= `DCD_OP_XOR) wm = ex_dst_reg[0] ? 2'b10 : 2'b01;
    end
  end

  dcd_regfile #(.W(32), .N(8), .AW(3)) u_rf (
    .mclk_in      (mclk_in),
    .resetn_in    (resetn_in),
    .rda_addr_in  (op_srca_in[3:1]),
    .rdb_addr_in  (op_srcb_in[3:1]),
    .rda_data_out (rd_a),
    .rdb_data_out (rd_b),
    .wr0_en_in    (we0),
    .wr0_addr_in  (ex_dst_reg[3:1]),
    .wr0_half_in  (wm),
    .wr0_data_in  (res),
    .wr1_en_in    (we1),
    .wr1_addr_in  (ex_dst_reg[3:1] ^ 3'h1),
    .wr1_data_in  (res2)
  );

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc0_reg      <= 40'h0;
      acc1_reg      <= 40'h0;
      acc0_out      <= 40'h0;
      acc1_out      <= 40'h0;
      res_valid_out <= 1'b0;
      res_data_out  <= 32'h0;
    end else begin
      acc0_reg      <= acc0_next;
      acc1_reg      <= acc1_next;
      acc0_out      <= acc0_next;
      acc1_out      <= acc1_next;
      res_valid_out <= we0;
      // Result word holds between writes
      if (we0) res_data_out <= res;
    end
  end

  // ----------------------------------------
  // Address unit
  // ----------------------------------------
  reg [31:0] idx_reg [0:3];
  reg [31:0] mod_reg [0:3];
  reg [31:0] len_reg [0:3];
  reg [31:0] bas_reg [0:3];
  reg [31:0] ptr_reg [0:7];
  integer    k;

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (k = 0; k < 4; k = k + 1) begin
        idx_reg[k] <= 32'h0;
        mod_reg[k] <= 32'h0;
        len_reg[k] <= 32'h0;
        bas_reg[k] <= 32'h0;
      end
      for (k = 0; k < 8; k = k + 1) ptr_reg[k] <= 32'h0;
      addr_valid_out <= 1'b0;
      addr0_out      <= 32'h0;
      addr1_out      <= 32'h0;
    end else begin
      addr_valid_out <= agen_valid_in;
      if (agen_valid_in) begin
        addr0_out <= idx_reg[agen_set_in];
        addr1_out <= ptr_reg[agen_ptr_in] + agen_off_in;
        idx_reg[agen_set_in] <= circ(idx_reg[agen_set_in], mod_reg[agen_set_in],
                                     len_reg[agen_set_in], bas_reg[agen_set_in]);
      end
      // An explicit load wins over the post-modify of the same index
      if (ald_valid_in) begin
        if (ald_sel_in[`DCD_ALD_PTR]) ptr_reg[ald_sel_in[2:0]] <= ald_data_in;
        else case (ald_sel_in[3:2])
          2'h0:    idx_reg[ald_sel_in[1:0]] <= ald_data_in;
          2'h1:    mod_reg[ald_sel_in[1:0]] <= ald_data_in;
          2'h2:    len_reg[ald_sel_in[1:0]] <= ald_data_in;
          default: bas_reg[ald_sel_in[1:0]] <= ald_data_in;
        endcase
      end
    end
  end
endmodule

//--- src/dcd_map.vh
// Opcode, field and constant map for the compute datapath
`ifndef DCD_MAP_VH
`define DCD_MAP_VH
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define DCD_OP_W      5
`define DCD_OP_ADD    5'h00
`define DCD_OP_SUB    5'h01
`define DCD_OP_AND    5'h02
`define DCD_OP_OR     5'h03
`define DCD_OP_XOR    5'h04
`define DCD_OP_ADD2   5'h05
`define DCD_OP_SUB2   5'h06
`define DCD_OP_QUAD   5'h07
`define DCD_OP_MUL    5'h08
`define DCD_OP_POPC   5'h09
`define DCD_OP_SIGNB  5'h0A
`define DCD_OP_EXTR   5'h0B
`define DCD_OP_DEPO   5'h0C
`define DCD_OP_SHFT   5'h0D
`define DCD_OP_MAC    5'h0E
`define DCD_OP_DIVS   5'h0F
`define DCD_OP_RND    5'h10
`define DCD_OP_ADD2C  5'h11
`define DCD_OP_ADD8C  5'h12
`define DCD_OP_AVG8   5'h13
`define DCD_OP_SAA    5'h14
`define DCD_OP_ALIGN  5'h15
`define DCD_OP_PACK   5'h16
`define DCD_OP_MIN    5'h17
`define DCD_OP_MAX    5'h18
`define DCD_OP_VSRCH  5'h19
`define DCD_OP_ACCRD  5'h1A
// ----------------------------------------
// Constants and fields
// ----------------------------------------
`define DCD_POS32     32'h7FFFFFFF
`define DCD_NEG32     32'h80000000
`define DCD_POS16     16'h7FFF
`define DCD_NEG16     16'h8000
`define DCD_RND40     40'h0000008000
`define DCD_RND32     32'h00008000
`define DCD_ACC_W     40
`define DCD_ACC_W7    7'h28
`define DCD_SH_ARITH  2'h0
`define DCD_SH_LOGIC  2'h1
`define DCD_SH_ROT    2'h2
`define DCD_ALD_PTR   4
`endif

//--- src/dcd_regfile.v
// Compute register file: 8 x 32, two registered read ports, two write ports
`timescale 1ns/1ps
module dcd_regfile #(
  parameter W  = 32,
  parameter N  = 8,
  parameter AW = 3
) (
  input  wire          mclk_in,
  input  wire          resetn_in,
  input  wire [AW-1:0] rda_addr_in,
  input  wire [AW-1:0] rdb_addr_in,
  output reg  [W-1:0]  rda_data_out,
  output reg  [W-1:0]  rdb_data_out,
  input  wire          wr0_en_in,
  input  wire [AW-1:0] wr0_addr_in,
  input  wire [1:0]    wr0_half_in,
  input  wire [W-1:0]  wr0_data_in,
  input  wire          wr1_en_in,
  input  wire [AW-1:0] wr1_addr_in,
  input  wire [W-1:0]  wr1_data_in
);
  reg [W-1:0] mem_reg [0:N-1];
  integer i;

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (i = 0; i < N; i = i + 1) mem_reg[i] <= {W{1'b0}};
      rda_data_out <= {W{1'b0}};
      rdb_data_out <= {W{1'b0}};
    end else begin
      rda_data_out <= mem_reg[rda_addr_in];
      rdb_data_out <= mem_reg[rdb_addr_in];
      if (wr1_en_in) mem_reg[wr1_addr_in] <= wr1_data_in;
      // Half enables make the file look like sixteen 16-bit registers
      if (wr0_en_in && wr0_half_in[0]) mem_reg[wr0_addr_in][W/2-1:0] <= wr0_data_in[W/2-1:0];
      if (wr0_en_in && wr0_half_in[1]) mem_reg[wr0_addr_in][W-1:W/2] <= wr0_data_in[W-1:W/2];
    end
  end
endmodule

//--- testbench/dcd_core_monitor.sv
// Port-level checker for the compute datapath
`timescale 1ns/1ps
`include "dcd_map.vh"
module dcd_core_monitor (
  input wire                 mclk_in,
  input wire                 resetn_in,
  input wire                 op_valid_in,
  input wire [`DCD_OP_W-1:0] op_code_in,
  input wire                 op_ready_out,
  input wire                 res_valid_out,
  input wire [31:0]          res_data_out,
  input wire [39:0]          acc0_out,
  input wire [39:0]          acc1_out,
  input wire                 agen_valid_in,
  input wire                 addr_valid_out,
  input wire [31:0]          addr0_out,
  input wire [31:0]          addr1_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire take  = op_valid_in & op_ready_out;
  wire accop = (op_code_in == `DCD_OP_MAC) | (op_code_in == `DCD_OP_SAA) | (op_code_in == `DCD_OP_SHFT);
  // Unknown codes drop ready for one cycle but never start a write
  wire wrop  = take & ~accop & (op_code_in <= `DCD_OP_ACCRD);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // Op port
  // ----------------------------------------
  chk_write_bubble: assert property (wrop |=> !op_ready_out)
    else $error("ready stayed high after a write op");
  chk_bubble_one: assert property (!op_ready_out |=> op_ready_out)
    else $error("ready low for more than one cycle");
  chk_result_pulse: assert property (wrop |-> ##2 res_valid_out ##1 !res_valid_out)
    else $error("result pulse missing or too long");
  chk_result_cause: assert property (res_valid_out |-> $past(wrop, 2))
    else $error("result without a write op");
  chk_acc_silent: assert property (take && accop |-> ##2 !res_valid_out)
    else $error("accumulator op wrote a result");
  chk_acc_cause: assert property ((!$stable(acc0_out) || !$stable(acc1_out)) |-> $past(take && accop, 2))
    else $error("accumulator moved without its op");
  chk_result_hold: assert property (!res_valid_out |-> $stable(res_data_out))
    else $error("result data moved without a pulse");
  // ----------------------------------------
  // Address port
  // ----------------------------------------
  chk_addr_answer: assert property (agen_valid_in |=> addr_valid_out)
    else $error("no address answer");
  chk_addr_cause: assert property (addr_valid_out |-> $past(agen_valid_in))
    else $error("address answer without request");
  chk_addr_hold: assert property (!addr_valid_out |-> $stable(addr0_out) && $stable(addr1_out))
    else $error("addresses moved without request");
endmodule
bind dcd_core dcd_core_monitor u_mon (.mclk_in, .resetn_in, .op_valid_in, .op_code_in, .op_ready_out,
  .res_valid_out, .res_data_out, .acc0_out, .acc1_out, .agen_valid_in, .addr_valid_out, .addr0_out, .addr1_out);

//--- testbench/dcd_core_tb_top.sv
// Self-checking bench for the compute datapath
`timescale 1ns/1ps
`include "dcd_map.vh"
module dcd_core_tb_top;
  reg         mclk_in = 1'b0;
  reg         resetn_in = 1'b0;
  reg         aldv = 1'b0;
  reg  [4:0]  alds = 5'h00;
  reg  [31:0] aldd = 32'h0;
  reg         agv = 1'b0;
  reg  [1:0]  ags = 2'h0;
  reg  [2:0]  agp = 3'h0;
  reg  [31:0] ago = 32'h0;
  wire        ov, ordy, rv, av;
  wire [4:0]  oc, fl;
  wire [3:0]  od, oa;
  wire [31:0] oi, rd, a0, a1;
  wire [39:0] c0, c1;
  integer     error_cnt = 0;
  integer     checks_done = 0;
  always #25 mclk_in = ~mclk_in;
  dcd_seq_model seq (.mclk_in(mclk_in), .ready_in(ordy), .valid_out(ov), .code_out(oc), .dst_out(od),
    .srca_out(oa), .imm_out(oi), .flags_out(fl));
  dcd_core DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .op_valid_in(ov), .op_code_in(oc), .op_dst_in(od),
    .op_srca_in(oa), .op_srcb_in(od), .op_imm_in(oi), .op_use_imm_in(fl[4]), .op_half_in(fl[3]),
    .op_signed_in(fl[2]), .op_round_in(fl[1]), .op_sat_in(fl[0]), .op_ready_out(ordy), .res_valid_out(rv),
    .res_data_out(rd), .acc0_out(c0), .acc1_out(c1), .ald_valid_in(aldv), .ald_sel_in(alds),
    .ald_data_in(aldd), .agen_valid_in(agv), .agen_set_in(ags), .agen_ptr_in(agp), .agen_off_in(ago),
    .addr_valid_out(av), .addr0_out(a0), .addr1_out(a1));
  // ----------------------------------------
  // Compare tasks
  // ----------------------------------------
  task cmp_bit(input got, input exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
      end
    end
  endtask
  task cmp_word(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t word %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_acc(input [39:0] got, input [39:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t acc %h exp %h", $time, got, exp);
      end
    end
  endtask
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task wr_op(input [4:0] c, input [3:0] d, input [3:0] a, input [31:0] i, input [4:0] f, input [31:0] e);
    begin
      seq.issue(c, d, a, i, f);
      seq.idle;
      #1 cmp_bit(ordy, 1'b0);
      @(posedge mclk_in);
      #1 cmp_bit(rv, 1'b1);
      cmp_word(rd, e);
      @(posedge mclk_in);
      #1 cmp_bit(rv, 1'b0);
      @(posedge mclk_in);
    end
  endtask
  // Two accumulator ops back to back, both results seen one cycle apart
  task acc_pair(input [4:0] ca, input [31:0] ia, input [4:0] fa, input [4:0] cb, input [31:0] ib,
                input [4:0] fb, input [39:0] pa, input [39:0] qa, input [39:0] pb, input [39:0] qb);
    begin
      seq.issue(ca, 4'h0, 4'h2, ia, fa);
      seq.issue(cb, 4'h0, 4'h2, ib, fb);
      seq.idle;
      #1 cmp_acc(c0, pa);
      cmp_acc(c1, qa);
      cmp_bit(rv, 1'b0);
      @(posedge mclk_in);
      #1 cmp_acc(c0, pb);
      cmp_acc(c1, qb);
      @(posedge mclk_in);
    end
  endtask
  task ald(input [4:0] s, input [31:0] d);
    begin
      aldv <= 1'b1;
      alds <= s;
      aldd <= d;
      @(posedge mclk_in);
    end
  endtask
  task agen(input [1:0] s, input [31:0] o, input [31:0] e0, input [31:0] e1);
    begin
      agv <= 1'b1;
      ags <= s;
      agp <= 3'h3;
      ago <= o;
      @(posedge mclk_in);
      agv <= 1'b0;
      ago <= ~o;
      #1 cmp_bit(av, 1'b1);
      cmp_word(a0, e0);
      cmp_word(a1, e1);
      @(posedge mclk_in);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task do_reset;
    begin
      @(posedge mclk_in);
      resetn_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      resetn_in <= 1'b1;
      #1 cmp_bit(ordy, 1'b1);
      cmp_bit(rv, 1'b0);
      cmp_acc(c0, 40'h0);
      cmp_word(a0, 32'h0);
      @(posedge mclk_in);
    end
  endtask
  task s_alu;
    begin
      wr_op(`DCD_OP_ADD, 4'h2, 4'h0, 32'h12345678, 5'h10, 32'h12345678);
      wr_op(`DCD_OP_XOR, 4'h4, 4'h2, 32'hFFFF0000, 5'h10, 32'hEDCB5678);
      wr_op(`DCD_OP_POPC, 4'h6, 4'h2, 32'h0, 5'h10, 32'h0000000D);
      wr_op(`DCD_OP_MUL, 4'h6, 4'h2, 32'h3, 5'h10, 32'h369D0368);
      wr_op(`DCD_OP_ADD, 4'h7, 4'h2, 32'h1, 5'h18, 32'h56795679);
      wr_op(`DCD_OP_ADD, 4'h6, 4'h6, 32'h0, 5'h10, 32'h56790368);
      wr_op(`DCD_OP_SUB, 4'h8, 4'h0, 32'h1, 5'h10, 32'hFFFFFFFF);
      wr_op(`DCD_OP_SIGNB, 4'hA, 4'h8, 32'h0, 5'h10, 32'h0000001F);
    end
  endtask
  task s_acc;
    begin
      wr_op(`DCD_OP_ADD, 4'h2, 4'h0, 32'h0003FFFF, 5'h10, 32'h0003FFFF);
      acc_pair(`DCD_OP_MAC, 32'h00050002, 5'h14, `DCD_OP_MAC, 32'h00050002, 5'h10,
               40'hFFFFFFFFFE, 40'hF, 40'h000001FFFC, 40'h1E);
      acc_pair(`DCD_OP_SHFT, 32'h0000003C, 5'h10, `DCD_OP_SAA, 32'h01010101, 5'h10,
               40'h0000001FFF, 40'h1E, 40'h00000021FE, 40'h1E);
    end
  endtask
  task s_ops;
    begin
      wr_op(`DCD_OP_ADD2, 4'hC, 4'h6, 32'h00010001, 5'h10, 32'h567A0369);
      wr_op(`DCD_OP_QUAD, 4'hC, 4'h6, 32'h00010001, 5'h10, 32'h567A0369);
      wr_op(`DCD_OP_ADD, 4'hE, 4'hE, 32'h0, 5'h10, 32'h56780367);
      wr_op(`DCD_OP_MIN, 4'hC, 4'h4, 32'h5, 5'h10, 32'hEDCB5678);
      wr_op(`DCD_OP_MAX, 4'hC, 4'h4, 32'h5, 5'h10, 32'h00000005);
      wr_op(`DCD_OP_VSRCH, 4'hC, 4'h6, 32'h80007000, 5'h10, 32'h56797000);
      wr_op(`DCD_OP_ADD8C, 4'hC, 4'h4, 32'h20405090, 5'h10, 32'hFFFFA6FF);
      wr_op(`DCD_OP_AVG8, 4'hC, 4'h4, 32'h01020304, 5'h10, 32'h77672D3E);
      wr_op(`DCD_OP_PACK, 4'hC, 4'h4, 32'h11223344, 5'h10, 32'hCB782244);
      wr_op(`DCD_OP_ALIGN, 4'hC, 4'h4, 32'h1, 5'h10, 32'h78000000);
      wr_op(`DCD_OP_ADD2C, 4'hC, 4'h6, 32'h40007FFF, 5'h10, 32'h7FFF7FFF);
      wr_op(`DCD_OP_DIVS, 4'hC, 4'h6, 32'h1000, 5'h10, 32'h9CF206D1);
      wr_op(`DCD_OP_RND, 4'hC, 4'h4, 32'h0, 5'h10, 32'hFFFFEDCB);
      wr_op(`DCD_OP_EXTR, 4'hC, 4'h4, 32'h10C, 5'h14, 32'hFFFFFFB5);
      wr_op(`DCD_OP_DEPO, 4'hC, 4'h4, 32'h00AB0108, 5'h10, 32'hEDCBAB78);
      wr_op(`DCD_OP_ACCRD, 4'hC, 4'h0, 32'h0, 5'h02, 32'h0000A1FE);
    end
  endtask
  task s_addr;
    begin
      ald(5'h00, 32'h100);
      ald(5'h04, 32'h10);
      ald(5'h13, 32'h2000);
      ald(5'h0D, 32'h40);
      ald(5'h09, 32'h20);
      ald(5'h05, 32'h8);
      ald(5'h01, 32'h58);
      aldv <= 1'b0;
      agen(2'h0, 32'h4, 32'h100, 32'h2004);
      agen(2'h0, 32'h4, 32'h110, 32'h2004);
      agen(2'h1, 32'h8, 32'h58, 32'h2008);
      agen(2'h1, 32'h8, 32'h40, 32'h2008);
    end
  endtask
  task wrap_up;
    begin
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
  initial begin
    do_reset;
    s_alu;
    s_acc;
    s_ops;
    s_addr;
    do_reset;
    wrap_up;
  end
endmodule

//--- testbench/dcd_seq_model.sv
// Sequencer model offering decoded ops on the op port
`timescale 1ns/1ps
module dcd_seq_model (
  input  wire        mclk_in,
  input  wire        ready_in,
  output reg         valid_out,
  output reg  [4:0]  code_out,
  output reg  [3:0]  dst_out,
  output reg  [3:0]  srca_out,
  output reg  [31:0] imm_out,
  output reg  [4:0]  flags_out
);
  initial begin
    valid_out = 1'b0;
    code_out = 5'h1F;
    dst_out = 4'h0;
    srca_out = 4'h0;
    imm_out = 32'h0;
    flags_out = 5'h00;
  end
  // Call at a rising edge; returns at the edge that takes the op
  task issue(input [4:0] c, input [3:0] d, input [3:0] a, input [31:0] i, input [4:0] f);
    begin
      valid_out <= 1'b1;
      code_out <= c;
      dst_out <= d;
      srca_out <= a;
      imm_out <= i;
      flags_out <= f;
      // A stuck interlock is caught by the bench watchdog
      @(posedge mclk_in);
      while (ready_in !== 1'b1)
        @(posedge mclk_in);
    end
  endtask
  // Released fields other than srca_out must not keep showing the last op
  task idle;
    begin
      valid_out <= 1'b0;
      code_out <= 5'h1F;
      dst_out <= ~dst_out;
      imm_out <= ~imm_out;
      flags_out <= ~flags_out;
    end
  endtask
endmodule
